// *** hsd_pkg.sv ***
package hsd_pkg;
	localparam int NUM_DRV = 4;
	localparam int AW      = 8;
	localparam int DW      = 8;

	// device register byte offsets
	localparam logic [7:0] HS_CTRL_ADDR   = 8'h08;
	localparam logic [7:0] HS_STATUS_ADDR = 8'h0b;
	localparam logic [7:0] HS_PWMSEL_ADDR = 8'h0c;
	localparam logic [7:0] HS_FAULT_ADDR  = 8'h0d;
	localparam logic [7:0] HS_MASK_ADDR   = 8'h0e;
	localparam logic [7:0] HB_DIAG_ADDR   = 8'h0f;

	// control register fields
	localparam int CTRL_EN_LSB  = 0;
	localparam int CTRL_SRC_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// fault register bit positions
	localparam int FLT_OVER_TEMP  = 0;
	localparam int FLT_OVER_CUR   = 1;
	localparam int FLT_OVER_VOLT  = 2;
	localparam int FLT_UNDER_VOLT = 3;
	localparam int FLT_PUMP_ERR   = 4;
	localparam int FLT_W          = 5;
	localparam logic [4:0] FAULT_RESET = 5'h00;
	localparam logic [4:0] MASK_RESET  = 5'h00;

	// host software port offsets
	localparam logic [2:0] H_TARGET_ADDR = 3'h0;
	localparam logic [2:0] H_WDATA_ADDR  = 3'h1;
	localparam logic [2:0] H_CMD_ADDR    = 3'h2;
	localparam logic [2:0] H_STATUS_ADDR = 3'h3;
	localparam logic [2:0] H_RESULT_ADDR = 3'h4;
	localparam int CMD_READ  = 0;
	localparam int CMD_SLEEP = 1;

	typedef enum logic [1:0] {
		HSD_IDLE,
		HSD_WRITE,
		HSD_READ,
		HSD_CAPTURE
	} hsd_host_state_type;
endpackage

// *** hsd_link_if.sv ***
`timescale 1ns/1ps
interface hsd_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;

	modport device (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata
	);
endinterface

// *** hsd_channel.sv ***
`timescale 1ns/1ps
module hsd_channel (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// per-driver inputs
	input  wire logic trip_event_i,
	input  wire logic trip_clear_i,
	input  wire logic en_next_i,
	input  wire logic gate_next_i,
	// per-driver outputs
	output logic      trip_flag_o,
	output logic      drive_o
);
	logic trip_flag_next;

	// sticky over-current flag, set wins over write-one-clear
	assign trip_flag_next = trip_event_i | (trip_flag_o & ~trip_clear_i);

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			trip_flag_o <= 1'b0;
		else
			trip_flag_o <= trip_flag_next;
	end

	// driver stays off while its own flag or any global gate is up
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			drive_o <= 1'b0;
		else
			drive_o <= en_next_i & ~trip_flag_next & ~gate_next_i;
	end
endmodule

// *** hsd_device.sv ***
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module hsd_device
	import hsd_pkg::*;
(
	// clock and reset
	input  wire logic               core_clk_i,
	input  wire logic               rst_i,
	// register link
	hsd_link_if.device              link,
	// analog sense inputs, asynchronous
	input  wire logic [NUM_DRV-1:0] over_current_fault_i,
	input  wire logic [NUM_DRV-1:0] hs_open_short_flag_i,
	input  wire logic [NUM_DRV-1:0] hb_open_short_flag_i,
	input  wire logic               over_temperature_fault_i,
	input  wire logic               over_voltage_fault_i,
	input  wire logic               under_voltage_fault_i,
	input  wire logic               charge_pump_voltage_error_i,
	// on-chip state, same clock
	input  wire logic               low_power_mode_i,
	input  wire logic [NUM_DRV-1:0] hb_high_diag_source_en_i,
	input  wire logic [NUM_DRV-1:0] hb_low_diag_source_en_i,
	input  wire logic [NUM_DRV-1:0] partner_low_side_en_i,
	// driver outputs
	output logic [NUM_DRV-1:0]      hs_drive_o,
	output logic [NUM_DRV-1:0]      hs_diag_source_o,
	output logic [NUM_DRV-1:0]      hs_pwm_sel_o,
	output logic [NUM_DRV-1:0]      hb_diag_invalid_o,
	output logic                    irq_o
);
	import hsd_pkg::*;

	localparam int SYNC_W = 3 * NUM_DRV + 4;

	logic [SYNC_W-1:0]  sync1_reg;
	logic [SYNC_W-1:0]  sync2_reg;
	logic [NUM_DRV-1:0] overcur_s;
	logic [NUM_DRV-1:0] hs_os_s;
	logic [NUM_DRV-1:0] hb_os_s;
	logic               overtemp_s;
	logic               overvolt_s;
	logic               undervolt_s;
	logic               pump_err_s;

	logic [7:0]         ctrl_reg;
	logic [7:0]         ctrl_next;
	logic [NUM_DRV-1:0] pwm_sel_reg;
	logic [FLT_W-1:0]   fault_reg;
	logic [FLT_W-1:0]   fault_next;
	logic [FLT_W-1:0]   fault_event;
	logic [FLT_W-1:0]   mask_reg;
	logic [NUM_DRV-1:0] overcur_flag;
	logic [NUM_DRV-1:0] overcur_event;
	logic [NUM_DRV-1:0] overcur_clear;
	logic [NUM_DRV-1:0] hs_os_reg;
	logic [7:0]         rdata_reg;
	logic               low_power_d_reg;
	logic               low_power_entry;
	logic               gate_next;
	logic               wr_ctrl;
	logic               wr_status;
	logic               wr_fault;

	////////////////////////////////////////////////////////////////////////////
	// two-stage synchroniser for all analog inputs
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= {over_current_fault_i, hs_open_short_flag_i, hb_open_short_flag_i,
				over_temperature_fault_i, over_voltage_fault_i, under_voltage_fault_i,
				charge_pump_voltage_error_i};
			sync2_reg <= sync1_reg;
		end
	end

	assign overcur_s   = sync2_reg[SYNC_W-1 -: NUM_DRV];
	assign hs_os_s     = sync2_reg[2*NUM_DRV+3 -: NUM_DRV];
	assign hb_os_s     = sync2_reg[NUM_DRV+3 -: NUM_DRV];
	assign overtemp_s  = sync2_reg[3];
	assign overvolt_s  = sync2_reg[2];
	assign undervolt_s = sync2_reg[1];
	assign pump_err_s  = sync2_reg[0];

	////////////////////////////////////////////////////////////////////////////
	// write decode
	assign wr_ctrl   = link.wr && (link.addr == HS_CTRL_ADDR);
	assign wr_status = link.wr && (link.addr == HS_STATUS_ADDR);
	assign wr_fault  = link.wr && (link.addr == HS_FAULT_ADDR);

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			low_power_d_reg <= 1'b0;
		else
			low_power_d_reg <= low_power_mode_i;
	end

	assign low_power_entry = low_power_mode_i & ~low_power_d_reg;

	////////////////////////////////////////////////////////////////////////////
	// control register; hardware clears win over a same-cycle write
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = link.wdata;
		if (low_power_entry)
			ctrl_next[CTRL_EN_LSB +: NUM_DRV] = '0;
		if (overtemp_s)
			ctrl_next = CTRL_RESET;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ctrl_reg <= CTRL_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			pwm_sel_reg <= '0;
		else if (link.wr && (link.addr == HS_PWMSEL_ADDR))
			pwm_sel_reg <= link.wdata[NUM_DRV-1:0];
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			mask_reg <= MASK_RESET;
		else if (link.wr && (link.addr == HS_MASK_ADDR))
			mask_reg <= link.wdata[FLT_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// captured faults, set wins over write-one-clear
	assign overcur_event = overcur_s & ~ctrl_reg[CTRL_SRC_LSB +: NUM_DRV];
	assign overcur_clear = wr_status ? link.wdata[NUM_DRV-1:0] : '0;

	always_comb
	begin
		fault_event                 = '0;
		fault_event[FLT_OVER_TEMP]  = overtemp_s;
		fault_event[FLT_OVER_CUR]   = |overcur_event;
		fault_event[FLT_OVER_VOLT]  = overvolt_s;
		fault_event[FLT_UNDER_VOLT] = undervolt_s;
		fault_event[FLT_PUMP_ERR]   = pump_err_s;
		fault_next = fault_event | (fault_reg & ~(wr_fault ? link.wdata[FLT_W-1:0] : '0));
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			fault_reg <= FAULT_RESET;
		else
			fault_reg <= fault_next;
	end

	// any captured fault or live supply fault holds every driver off
	assign gate_next = (|fault_next) | overvolt_s | undervolt_s;

	////////////////////////////////////////////////////////////////////////////
	// per-driver protection channels
	genvar g;
	generate
		for (g = 0; g < NUM_DRV; g++)
		begin : g_chan
			hsd_channel u_chan (
				.core_clk_i   (core_clk_i),
				.rst_i        (rst_i),
				.trip_event_i (overcur_event[g]),
				.trip_clear_i (overcur_clear[g]),
				.en_next_i    (ctrl_next[CTRL_EN_LSB + g]),
				.gate_next_i  (gate_next),
				.trip_flag_o  (overcur_flag[g]),
				.drive_o      (hs_drive_o[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hs_diag_source_o  <= '0;
			hs_pwm_sel_o      <= '0;
			hs_os_reg         <= '0;
			hb_diag_invalid_o <= '0;
			irq_o             <= 1'b0;
		end
		else
		begin
			hs_diag_source_o <= ctrl_next[CTRL_SRC_LSB +: NUM_DRV];
			hs_pwm_sel_o     <= pwm_sel_reg;
			hs_os_reg        <= hs_os_s;
			hb_diag_invalid_o <= (hb_high_diag_source_en_i & ~hb_low_diag_source_en_i
				& ~partner_low_side_en_i & ~hb_os_s)
				| (~hb_high_diag_source_en_i & hb_low_diag_source_en_i
				& ~partner_low_side_en_i & hb_os_s);
			irq_o <= |(fault_next & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_reg <= 8'h00;
		else if (link.rd)
		begin
			case (link.addr)
				HS_CTRL_ADDR:   rdata_reg <= ctrl_reg;
				HS_STATUS_ADDR: rdata_reg <= {hs_os_reg, overcur_flag};
				HS_PWMSEL_ADDR: rdata_reg <= {4'h0, pwm_sel_reg};
				HS_FAULT_ADDR:  rdata_reg <= {3'h0, fault_reg};
				HS_MASK_ADDR:   rdata_reg <= {3'h0, mask_reg};
				HB_DIAG_ADDR:   rdata_reg <= {4'h0, hb_diag_invalid_o};
				default:        rdata_reg <= 8'h00;
			endcase
		end
		else
			rdata_reg <= 8'h00;
	end

	assign link.rdata = rdata_reg;
endmodule

// *** hsd_host.sv ***
`timescale 1ns/1ps
module hsd_host
	import hsd_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// software port
	input  wire logic [2:0] sw_addr_i,
	input  wire logic [7:0] sw_wdata_i,
	input  wire logic       sw_wr_i,
	input  wire logic       sw_rd_i,
	output logic [7:0]      sw_rdata_o,
	// status
	output logic            busy_o,
	output logic            low_power_req_o,
	// register link
	hsd_link_if.host        link
);
	import hsd_pkg::*;

	hsd_host_state_type state_reg;
	logic [7:0]         target_reg;
	logic [7:0]         result_reg;
	logic [7:0]         ctrl_shadow_reg;
	logic [7:0]         addr_reg;
	logic [7:0]         wdata_reg;
	logic               wr_reg;
	logic               rd_reg;
	logic               done_reg;
	logic               sleep_pend_reg;
	logic               idle;
	logic [7:0]         safe_data;

	assign idle = (state_reg == HSD_IDLE);

	// a driver whose diagnostic source is requested is kept off
	assign safe_data = (target_reg == HS_CTRL_ADDR) ?
		{sw_wdata_i[7:4], sw_wdata_i[3:0] & ~sw_wdata_i[7:4]} : sw_wdata_i;

	////////////////////////////////////////////////////////////////////////////
	// command sequencer
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg       <= HSD_IDLE;
			addr_reg        <= 8'h00;
			wdata_reg       <= 8'h00;
			wr_reg          <= 1'b0;
			rd_reg          <= 1'b0;
			result_reg      <= 8'h00;
			ctrl_shadow_reg <= CTRL_RESET;
			sleep_pend_reg  <= 1'b0;
			low_power_req_o <= 1'b0;
		end
		else
		begin
			wr_reg          <= 1'b0;
			rd_reg          <= 1'b0;
			low_power_req_o <= 1'b0;
			case (state_reg)
				HSD_IDLE:
				begin
					if (sw_wr_i && sw_addr_i == H_WDATA_ADDR)
					begin
						addr_reg  <= target_reg;
						wdata_reg <= safe_data;
						wr_reg    <= 1'b1;
						if (target_reg == HS_CTRL_ADDR)
							ctrl_shadow_reg <= safe_data;
						state_reg <= HSD_WRITE;
					end
					else if (sw_wr_i && sw_addr_i == H_CMD_ADDR && sw_wdata_i[CMD_SLEEP])
					begin
						addr_reg        <= HS_CTRL_ADDR;
						wdata_reg       <= {4'h0, ctrl_shadow_reg[3:0]};
						ctrl_shadow_reg <= {4'h0, ctrl_shadow_reg[3:0]};
						wr_reg          <= 1'b1;
						sleep_pend_reg  <= 1'b1;
						state_reg       <= HSD_WRITE;
					end
					else if (sw_wr_i && sw_addr_i == H_CMD_ADDR && sw_wdata_i[CMD_READ])
					begin
						addr_reg  <= target_reg;
						rd_reg    <= 1'b1;
						state_reg <= HSD_READ;
					end
				end
				HSD_WRITE:
				begin
					low_power_req_o <= sleep_pend_reg;
					sleep_pend_reg  <= 1'b0;
					state_reg       <= HSD_IDLE;
				end
				HSD_READ:
					state_reg <= HSD_CAPTURE;
				HSD_CAPTURE:
				begin
					result_reg <= link.rdata;
					state_reg  <= HSD_IDLE;
				end
				default:
					state_reg <= HSD_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			target_reg <= 8'h00;
		else if (sw_wr_i && sw_addr_i == H_TARGET_ADDR)
			target_reg <= sw_wdata_i;
	end

	// done is sticky; a new completion wins over a clear
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			done_reg <= 1'b0;
		else if ((state_reg == HSD_WRITE) || (state_reg == HSD_CAPTURE))
			done_reg <= 1'b1;
		else if (sw_wr_i && sw_addr_i == H_STATUS_ADDR && sw_wdata_i[0])
			done_reg <= 1'b0;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sw_rdata_o <= 8'h00;
			busy_o     <= 1'b0;
		end
		else
		begin
			busy_o <= ~idle | (sw_wr_i && (sw_addr_i == H_WDATA_ADDR || sw_addr_i == H_CMD_ADDR));
			if (sw_rd_i)
			begin
				case (sw_addr_i)
					H_TARGET_ADDR: sw_rdata_o <= target_reg;
					H_STATUS_ADDR: sw_rdata_o <= {6'h00, ~idle, done_reg};
					H_RESULT_ADDR: sw_rdata_o <= result_reg;
					default:       sw_rdata_o <= 8'h00;
				endcase
			end
			else
				sw_rdata_o <= 8'h00;
		end
	end

	assign link.addr  = addr_reg;
	assign link.wdata = wdata_reg;
	assign link.wr    = wr_reg;
	assign link.rd    = rd_reg;
endmodule

// *** hsd_link_properties.sv ***
`timescale 1ns/1ps
module hsd_link_properties (
	// clock and reset
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	// link signals
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// device pins and the host sleep request
	input wire logic [3:0] hs_drive_o,
	input wire logic [3:0] hs_diag_source_o,
	input wire logic [3:0] over_current_fault_i,
	input wire logic       over_temperature_fault_i,
	input wire logic       over_voltage_fault_i,
	input wire logic       under_voltage_fault_i,
	input wire logic       low_power_mode_i,
	input wire logic       low_power_req_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	chk_read_slot:
	assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside its slot");
	chk_one_strobe:
	assert property (!(wr && rd))
		else $error("both strobes at once");
	chk_source_bits:
	assert property (wr && addr == 8'h08 && !over_temperature_fault_i
		&& !$past(over_temperature_fault_i) && !$past(over_temperature_fault_i, 2)
		|=> {hs_diag_source_o, 4'h0} == ($past(wdata) & 8'hf0))
		else $error("sources differ from written bits");
	chk_heat_clears:
	assert property (over_temperature_fault_i [*3]
		|=> hs_drive_o == 4'h0 && hs_diag_source_o == 4'h0)
		else $error("over-temperature left outputs on");
	chk_over_volt:
	assert property (over_voltage_fault_i [*3] |=> hs_drive_o == 4'h0)
		else $error("over-voltage left drivers on");
	chk_under_volt:
	assert property (under_voltage_fault_i [*3] |=> hs_drive_o == 4'h0)
		else $error("under-voltage left drivers on");
	chk_overcurrent_off:
	assert property ((over_current_fault_i != 4'h0 && hs_diag_source_o == 4'h0) [*3]
		|=> hs_drive_o == 4'h0)
		else $error("over-current left drivers on");
	chk_drive_rise:
	assert property ((hs_drive_o & ~$past(hs_drive_o)) != 4'h0 |-> $past(wr) || $past(wr, 2))
		else $error("driver turned on without a write");
	chk_sleep_entry:
	assert property ($rose(low_power_mode_i) |=> hs_drive_o == 4'h0)
		else $error("driver still on after sleep entry");
	chk_sleep_prep:
	assert property (low_power_req_o
		|-> $past(wr) && $past(addr) == 8'h08 && ($past(wdata) & 8'hf0) == 8'h00)
		else $error("sleep request without sources cleared");
endmodule

// *** high_side_driver_control_bench.sv ***
`timescale 1ns/1ps
module high_side_driver_control_bench;
	import hsd_pkg::*;
	logic       core_clk_i;
	logic       rst_i;
	logic [2:0] sw_addr_i;
	logic [7:0] sw_wdata_i;
	logic       sw_wr_i;
	logic       sw_rd_i;
	logic [7:0] sw_rdata_o;
	logic       busy_o;
	logic       low_power_req_o;
	logic [3:0] over_current_fault_i;
	logic [3:0] hs_open_short_flag_i;
	logic [3:0] hb_open_short_flag_i;
	logic       over_temperature_fault_i;
	logic       over_voltage_fault_i;
	logic       under_voltage_fault_i;
	logic       charge_pump_voltage_error_i;
	logic       low_power_mode_i;
	logic [3:0] hb_high_diag_source_en_i;
	logic [3:0] hb_low_diag_source_en_i;
	logic [3:0] partner_low_side_en_i;
	logic [3:0] hs_drive_o;
	logic [3:0] hs_diag_source_o;
	logic [3:0] hs_pwm_sel_o;
	logic [3:0] hb_diag_invalid_o;
	logic       irq_o;
	logic       hit;
	int         fail_count = 0;
	int         checks = 0;

	hsd_link_if link ();
	hsd_device hsd_device_inst (.core_clk_i, .rst_i, .link(link), .over_current_fault_i,
		.hs_open_short_flag_i, .hb_open_short_flag_i, .over_temperature_fault_i,
		.over_voltage_fault_i, .under_voltage_fault_i, .charge_pump_voltage_error_i,
		.low_power_mode_i, .hb_high_diag_source_en_i, .hb_low_diag_source_en_i,
		.partner_low_side_en_i, .hs_drive_o, .hs_diag_source_o, .hs_pwm_sel_o,
		.hb_diag_invalid_o, .irq_o);
	hsd_host hsd_host_inst (.core_clk_i, .rst_i, .sw_addr_i, .sw_wdata_i, .sw_wr_i,
		.sw_rd_i, .sw_rdata_o, .busy_o, .low_power_req_o, .link(link));
	hsd_link_properties hsd_link_properties_inst (.core_clk_i, .rst_i, .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .hs_drive_o,
		.hs_diag_source_o, .over_current_fault_i, .over_temperature_fault_i,
		.over_voltage_fault_i, .under_voltage_fault_i, .low_power_mode_i, .low_power_req_o);

	initial
	begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bad(input string m);
		fail_count++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
			bad($sformatf("register %h expected %h", g, e));
	endtask
	task automatic cmp_pin(input logic [3:0] g, input logic [3:0] e);
		checks++;
		if (g !== e)
			bad($sformatf("pins %h expected %h", g, e));
	endtask
	task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge core_clk_i);
		sw_wr_i <= 1'b0;
	endtask
	task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge core_clk_i);
		sw_rd_i <= 1'b0;
		#1 d = sw_rdata_o;
	endtask
	// polls the sticky done bit, bounded
	task automatic wait_done;
		logic [7:0] s;
		s = 8'h00;
		for (int n = 0; n < 20 && s[0] !== 1'b1; n++)
			sw_rd(H_STATUS_ADDR, s);
		if (s[0] !== 1'b1)
		begin
			bad("host never done");
			test_done;
		end
	endtask
	task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
		sw_wr(H_TARGET_ADDR, a);
		sw_wr(H_STATUS_ADDR, 8'h01);
		sw_wr(H_WDATA_ADDR, d);
		wait_done;
	endtask
	task automatic dev_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		sw_wr(H_TARGET_ADDR, a);
		sw_wr(H_STATUS_ADDR, 8'h01);
		sw_wr(H_CMD_ADDR, 8'h01);
		wait_done;
		sw_rd(H_RESULT_ADDR, d);
		cmp_reg(d, e);
	endtask
	task automatic set_flt(input int k, input logic v);
		@(posedge core_clk_i);
		case (k)
			FLT_OVER_TEMP:  over_temperature_fault_i <= v;
			FLT_OVER_VOLT:  over_voltage_fault_i <= v;
			FLT_UNDER_VOLT: under_voltage_fault_i <= v;
			default: charge_pump_voltage_error_i <= v;
		endcase
		repeat (4) @(posedge core_clk_i);
	endtask
	task automatic hb_case(input logic [3:0] h, l, p, f, e);
		@(posedge core_clk_i);
		hb_high_diag_source_en_i <= h;
		hb_low_diag_source_en_i <= l;
		partner_low_side_en_i <= p;
		hb_open_short_flag_i <= f;
		repeat (4) @(posedge core_clk_i);
		cmp_pin(hb_diag_invalid_o, e);
		dev_rd(HB_DIAG_ADDR, {4'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i, over_current_fault_i, hs_open_short_flag_i,
			hb_open_short_flag_i, over_temperature_fault_i, over_voltage_fault_i,
			under_voltage_fault_i, charge_pump_voltage_error_i, low_power_mode_i,
			hb_high_diag_source_en_i, hb_low_diag_source_en_i, partner_low_side_en_i} = '0;
		rst_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		// reset values, read-only and unmapped places
		dev_wr(HB_DIAG_ADDR, 8'hff);
		dev_wr(8'h10, 8'hff);
		for (int i = 0; i < 8; i++)
			dev_rd(HS_CTRL_ADDR + 8'(i), 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			dev_wr(HS_CTRL_ADDR, 8'h01 << i);
			cmp_pin(hs_drive_o, 4'h1 << i);
			dev_wr(HS_CTRL_ADDR, 8'h10 << i);
			cmp_pin(hs_diag_source_o, 4'h1 << i);
			dev_rd(HS_CTRL_ADDR, 8'h10 << i);
		end
		dev_wr(HS_PWMSEL_ADDR, 8'h05);
		dev_rd(HS_PWMSEL_ADDR, 8'h05);
		cmp_pin(hs_pwm_sel_o, 4'h5);
		// over-current on driver 2 with its interrupt unmasked
		dev_wr(HS_CTRL_ADDR, 8'h0f);
		dev_wr(HS_MASK_ADDR, 8'h02);
		@(posedge core_clk_i);
		over_current_fault_i <= 4'h4;
		repeat (4) @(posedge core_clk_i);
		cmp_pin(hs_drive_o, 4'h0);
		cmp_pin({3'h0, irq_o}, 4'h1);
		over_current_fault_i <= 4'h0;
		dev_rd(HS_STATUS_ADDR, 8'h04);
		dev_rd(HS_FAULT_ADDR, 8'h02);
		dev_wr(HS_FAULT_ADDR, 8'h02);
		cmp_pin(hs_drive_o, 4'hb);
		cmp_pin({3'h0, irq_o}, 4'h0);
		dev_wr(HS_STATUS_ADDR, 8'h04);
		cmp_pin(hs_drive_o, 4'hf);
		// over-current is ignored while the diagnostic source is on
		dev_wr(HS_CTRL_ADDR, 8'h10);
		@(posedge core_clk_i);
		over_current_fault_i <= 4'h1;
		repeat (4) @(posedge core_clk_i);
		over_current_fault_i <= 4'h0;
		dev_rd(HS_STATUS_ADDR, 8'h00);
		dev_rd(HS_FAULT_ADDR, 8'h00);
		// supply, charge-pump and over-temperature faults, masked
		dev_wr(HS_CTRL_ADDR, 8'h0f);
		for (int k = FLT_OVER_VOLT; k <= FLT_PUMP_ERR; k++)
		begin
			set_flt(k, 1'b1);
			cmp_pin(hs_drive_o, 4'h0);
			set_flt(k, 1'b0);
			dev_rd(HS_FAULT_ADDR, 8'h01 << k);
			cmp_pin({3'h0, irq_o}, 4'h0);
			dev_wr(HS_FAULT_ADDR, 8'h01 << k);
			cmp_pin(hs_drive_o, 4'hf);
		end
		dev_wr(HS_CTRL_ADDR, 8'h3c);
		cmp_pin(hs_drive_o, 4'hc);
		set_flt(FLT_OVER_TEMP, 1'b1);
		cmp_pin(hs_diag_source_o, 4'h0);
		set_flt(FLT_OVER_TEMP, 1'b0);
		dev_rd(HS_CTRL_ADDR, 8'h00);
		dev_rd(HS_FAULT_ADDR, 8'h01);
		dev_wr(HS_FAULT_ADDR, 8'h01);
		// sleep preparation, then sleep entry
		dev_wr(HS_CTRL_ADDR, 8'h3c);
		sw_wr(H_CMD_ADDR, 8'h02);
		#1 cmp_pin({3'h0, busy_o}, 4'h1);
		hit = 1'b0;
		repeat (10)
		begin
			@(posedge core_clk_i);
			#1 hit = hit | low_power_req_o;
		end
		cmp_pin({3'h0, hit}, 4'h1);
		cmp_pin({3'h0, busy_o}, 4'h0);
		dev_rd(HS_CTRL_ADDR, 8'h0c);
		@(posedge core_clk_i);
		low_power_mode_i <= 1'b1;
		dev_rd(HS_CTRL_ADDR, 8'h00);
		cmp_pin(hs_drive_o, 4'h0);
		@(posedge core_clk_i);
		low_power_mode_i <= 1'b0;
		hs_open_short_flag_i <= 4'h9;
		dev_rd(HS_STATUS_ADDR, 8'h90);
		@(posedge core_clk_i);
		hs_open_short_flag_i <= 4'h0;
		dev_rd(HS_STATUS_ADDR, 8'h00);
		hb_case(4'h5, 4'ha, 4'h8, 4'he, 4'h3);
		hb_case(4'ha, 4'h5, 4'h0, 4'h4, 4'he);
		test_done;
	end
endmodule
